// ### rseq_top.sv
// reset sequencer: source merge, start-up delays, reset flags, reset values
`timescale 1ns/1ps
`default_nettype none
`include "rseq_defines.svh"
module rseq_top #(
  parameter int unsigned POWERON_DELAY_CYC = `RSEQ_POWERON_DELAY_CYC
) (
  // clock and power-on reset
  input wire logic clk,
  input wire logic rstn,
  // external sources (asynchronous pins)
  input wire logic external_reset_pin_n,
  input wire logic supply_low,
  // core status inputs (same clock)
  input wire logic wdt_expire,
  input wire logic low_power_mode,
  input wire logic halt_entry,
  input wire logic wdt_clear_insn,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // core reset outputs
  output logic core_hold,
  output rseq_pkg::rseq_init_t init_strobe,
  output logic low_voltage_reset,
  output logic wdt_count_clear,
  output logic timeout_flag,
  output logic powerdown_flag,
  // reset values handed to the core
  output logic [7:0] watchdog_control_reg,
  output logic [7:0] system_mode_reg,
  output logic [7:0] port_a_data,
  output logic [7:0] port_a_direction,
  output logic [2:0] stack_ptr,
  output logic timer_enable,
  output logic int_enable,
  // interrupt
  output logic irq
);
  logic [1:0] pin_sync_q;
  logic [1:0] low_sync_q;
  logic [`RSEQ_DELAY_W-1:0] filt_q;
  logic [`RSEQ_DELAY_W-1:0] cnt_q;
  logic [`RSEQ_DELAY_W-1:0] sst_cyc;
  rseq_pkg::rseq_state_t state_q;
  rseq_pkg::rseq_osc_t osc_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic avs_rd_q;
  logic pin_rst;
  logic wdt_run;
  logic wdt_sleep;
  logic wr_hit;
  logic full_rst;
  logic sleep_rst;

  // two-flop synchronisers for pin and supply monitor
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_sync_q <= 2'h0;
      low_sync_q <= 2'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[0], ~external_reset_pin_n};
      low_sync_q <= {low_sync_q[0], supply_low};
    end
  end

  // supply-low filter, short dips ignored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      filt_q <= '0;
      low_voltage_reset <= 1'b0;
    end else if (!low_sync_q[1]) begin
      filt_q <= '0;
      low_voltage_reset <= 1'b0;
    end else if (filt_q >= `RSEQ_DELAY_W'(`RSEQ_LOW_SUPPLY_FILTER_CYC)) begin
      low_voltage_reset <= 1'b1;
    end else begin
      filt_q <= filt_q + 1'b1;
    end
  end

  // source merge; pin/lvr outrank watchdog
  assign pin_rst = pin_sync_q[1] | low_voltage_reset;
  assign wdt_run = wdt_expire & ~low_power_mode & ~pin_rst;
  assign wdt_sleep = wdt_expire & low_power_mode & ~pin_rst;

  // full reset and low-power wake reset; watchdog causes taken only while running, pin/lvr full reset in any state
  assign full_rst = pin_rst | (wdt_run & (state_q == rseq_pkg::RSEQ_RUN));
  assign sleep_rst = wdt_sleep & (state_q == rseq_pkg::RSEQ_RUN);

  // wake start-up wait by oscillator source
  always_comb begin
    unique case (osc_q)
      rseq_pkg::RSEQ_OSC_XTAL: sst_cyc = `RSEQ_DELAY_W'(`RSEQ_SST_XTAL_CYC);
      rseq_pkg::RSEQ_OSC_SLOW_RC: sst_cyc = `RSEQ_DELAY_W'(`RSEQ_SST_SLOW_RC_CYC);
      default: sst_cyc = `RSEQ_DELAY_W'(`RSEQ_SST_RC_CYC);
    endcase
  end

  // sequencer: hold, delay, run, wake
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= rseq_pkg::RSEQ_POR_HOLD;
      cnt_q <= '0;
    end else if (pin_rst) begin
      state_q <= rseq_pkg::RSEQ_RST_HOLD;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        rseq_pkg::RSEQ_POR_HOLD, rseq_pkg::RSEQ_RST_HOLD: begin
          state_q <= rseq_pkg::RSEQ_DELAY;
          cnt_q <= '0;
        end
        rseq_pkg::RSEQ_DELAY: begin
          if (cnt_q >= POWERON_DELAY_CYC - 1) begin
            state_q <= rseq_pkg::RSEQ_RUN;
          end
          cnt_q <= cnt_q + 1'b1;
        end
        rseq_pkg::RSEQ_RUN: begin
          cnt_q <= '0;
          if (wdt_run) begin
            state_q <= rseq_pkg::RSEQ_RST_HOLD;
          end else if (wdt_sleep) begin
            state_q <= rseq_pkg::RSEQ_WAKE;
          end
        end
        rseq_pkg::RSEQ_WAKE: begin
          if (cnt_q >= sst_cyc - 1) begin
            state_q <= rseq_pkg::RSEQ_RUN;
          end
          cnt_q <= cnt_q + 1'b1;
        end
      endcase
    end
  end

  // core hold and init strobes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      core_hold <= 1'b1;
      init_strobe <= '{full_init: 1'b1, pc_sp_clear: 1'b1, poweron_init: 1'b1};
      wdt_count_clear <= 1'b1;
    end else begin
      core_hold <= pin_rst | (state_q != rseq_pkg::RSEQ_RUN) |
        (wdt_expire & (state_q == rseq_pkg::RSEQ_RUN));
      init_strobe.poweron_init <= 1'b0;
      init_strobe.full_init <= pin_rst | (wdt_run & state_q == rseq_pkg::RSEQ_RUN);
      init_strobe.pc_sp_clear <= pin_rst | (wdt_expire & state_q == rseq_pkg::RSEQ_RUN);
      wdt_count_clear <= pin_rst | (wdt_expire & state_q == rseq_pkg::RSEQ_RUN) |
        halt_entry | wdt_clear_insn;
    end
  end

  // reset flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timeout_flag <= 1'b0;
      powerdown_flag <= 1'b0;
    end else if (pin_rst) begin
      timeout_flag <= timeout_flag;
    end else if (wdt_expire && state_q == rseq_pkg::RSEQ_RUN) begin
      timeout_flag <= 1'b1;
      if (low_power_mode) begin
        powerdown_flag <= 1'b1;
      end
    end else if (halt_entry) begin
      powerdown_flag <= 1'b1;
    end
  end

  // watchdog control and mode registers, kept across a low-power wake
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      watchdog_control_reg <= `RSEQ_WATCHDOG_CONTROL_REG_RST;
      system_mode_reg <= `RSEQ_SYSTEM_MODE_REG_RST;
    end else if (full_rst) begin
      watchdog_control_reg <= `RSEQ_WATCHDOG_CONTROL_REG_RST;
      system_mode_reg <= `RSEQ_SYSTEM_MODE_REG_RST;
    end
  end

  // port data and direction, all pins inputs after reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      port_a_data <= `RSEQ_PORT_RST;
      port_a_direction <= `RSEQ_PORT_RST;
    end else if (full_rst) begin
      port_a_data <= `RSEQ_PORT_RST;
      port_a_direction <= `RSEQ_PORT_RST;
    end
  end

  // stack pointer: top after full reset, zero after a low-power wake
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stack_ptr <= `RSEQ_STACK_TOP;
    end else if (full_rst) begin
      stack_ptr <= `RSEQ_STACK_TOP;
    end else if (sleep_rst) begin
      stack_ptr <= `RSEQ_STACK_CLEAR;
    end
  end

  // interrupt and timer enables, off after full reset, kept on across a low-power wake, on again once running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer_enable <= 1'b0;
      int_enable <= 1'b0;
    end else if (full_rst) begin
      timer_enable <= 1'b0;
      int_enable <= 1'b0;
    end else if ((state_q == rseq_pkg::RSEQ_RUN) && !sleep_rst) begin
      int_enable <= 1'b1;
      timer_enable <= 1'b1;
    end
  end

  // bus write decode
  assign wr_hit = avs_write & ~avs_waitrequest & avs_byteenable[0];

  // interrupt status, write one to clear, a new event wins over the clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_q <= 3'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_hit && avs_address == `RSEQ_ADDR_IRQ_STAT) ?
        avs_writedata[2:0] : 3'h0)) |
        {wdt_expire & state_q == rseq_pkg::RSEQ_RUN, low_voltage_reset, pin_sync_q[1]};
    end
  end

  // interrupt mask and oscillator select
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_q <= 3'h0;
      osc_q <= rseq_pkg::RSEQ_OSC_RC;
    end else begin
      if (wr_hit && avs_address == `RSEQ_ADDR_IRQ_MASK) begin
        irq_mask_q <= avs_writedata[2:0];
      end
      if (wr_hit && avs_address == `RSEQ_ADDR_OSC_SEL) begin
        osc_q <= rseq_pkg::rseq_osc_t'(avs_writedata[1:0]);
      end
    end
  end

  // irq output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // avalon read path: one wait cycle per access
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_rd_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_rd_q <= (avs_read | avs_write) & avs_waitrequest & ~avs_rd_q;
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest & ~avs_rd_q);
      if (avs_read && avs_waitrequest && !avs_rd_q) begin
        unique case (avs_address)
          `RSEQ_ADDR_STATUS: avs_readdata <= {28'h000_0000, 1'b0, state_q == rseq_pkg::RSEQ_RUN,
            timeout_flag, powerdown_flag};
          `RSEQ_ADDR_IRQ_STAT: avs_readdata <= {29'h000_0000, irq_stat_q};
          `RSEQ_ADDR_IRQ_MASK: avs_readdata <= {29'h000_0000, irq_mask_q};
          `RSEQ_ADDR_OSC_SEL: avs_readdata <= {30'h000_0000, osc_q};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### rseq_defines.svh
// constants for the reset sequencer: timing counts, reset values, register map
`ifndef RSEQ_DEFINES_SVH
`define RSEQ_DEFINES_SVH
`define RSEQ_CLK_MHZ 200
`define RSEQ_POWERON_DELAY_MS 100
`define RSEQ_POWERON_DELAY_CYC (`RSEQ_POWERON_DELAY_MS * 1000 * `RSEQ_CLK_MHZ)
`define RSEQ_LOW_SUPPLY_FILTER_NS 1000
`define RSEQ_LOW_SUPPLY_FILTER_CYC ((`RSEQ_LOW_SUPPLY_FILTER_NS * `RSEQ_CLK_MHZ) / 1000)
`define RSEQ_SST_RC_CYC 16
`define RSEQ_SST_XTAL_CYC 1024
`define RSEQ_SST_SLOW_RC_CYC 2
`define RSEQ_WATCHDOG_CONTROL_REG_RST 8'h7a
`define RSEQ_SYSTEM_MODE_REG_RST 8'h03
`define RSEQ_PORT_RST 8'hff
`define RSEQ_STACK_TOP 3'h7
`define RSEQ_STACK_CLEAR 3'h0
`define RSEQ_ADDR_STATUS 4'h0
`define RSEQ_ADDR_IRQ_STAT 4'h4
`define RSEQ_ADDR_IRQ_MASK 4'h8
`define RSEQ_ADDR_OSC_SEL 4'hc
`define RSEQ_DELAY_W 32
`endif

// ### rseq_pkg.sv
// types shared by the reset sequencer
`default_nettype none
package rseq_pkg;
  typedef enum logic [4:0] {
    RSEQ_POR_HOLD = 5'b0_0001,
    RSEQ_RST_HOLD = 5'b0_0010,
    RSEQ_DELAY = 5'b0_0100,
    RSEQ_RUN = 5'b0_1000,
    RSEQ_WAKE = 5'b1_0000
  } rseq_state_t;
  // oscillator source, steers the wake start-up wait
  typedef enum logic [1:0] {
    RSEQ_OSC_RC = 2'h0,
    RSEQ_OSC_XTAL = 2'h1,
    RSEQ_OSC_SLOW_RC = 2'h2
  } rseq_osc_t;
  // init strobes toward the core
  typedef struct packed {
    logic full_init;
    logic pc_sp_clear;
    logic poweron_init;
  } rseq_init_t;
endpackage
`default_nettype wire

// ### rseq_props.sv
// assertions on the reset sequencer ports
`timescale 1ns/1ps
`default_nettype none
module rseq_props (
  // clock, reset, sources
  input wire logic clk,
  input wire logic rstn,
  input wire logic external_reset_pin_n,
  input wire logic supply_low,
  input wire logic wdt_expire,
  input wire logic low_power_mode,
  // results
  input wire logic core_hold,
  input wire rseq_pkg::rseq_init_t init_strobe,
  input wire logic low_voltage_reset,
  input wire logic timeout_flag,
  input wire logic powerdown_flag,
  input wire logic [7:0] watchdog_control_reg
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // expiry while running or asleep
  sequence s_run; wdt_expire && !low_power_mode && !core_hold; endsequence
  sequence s_lp; wdt_expire && low_power_mode; endsequence
  property p_to; s_run |-> ##[1:4] timeout_flag; endproperty
  property p_full; s_run |-> ##[1:4] init_strobe.full_init; endproperty
  property p_lp; s_lp |-> ##[1:4] timeout_flag && powerdown_flag; endproperty
  property p_sp; s_lp |-> ##[1:4] init_strobe.pc_sp_clear; endproperty
  property p_keep; s_lp |=> $stable(watchdog_control_reg) [*4]; endproperty
  property p_pin; (!external_reset_pin_n) [*6] |-> core_hold; endproperty
  property p_flag; !external_reset_pin_n |=> $stable({timeout_flag, powerdown_flag}); endproperty
  property p_lvr; $rose(low_voltage_reset) |-> $past(supply_low, 150); endproperty
  a_to: assert property (p_to) else $error("timeout flag late");
  a_full: assert property (p_full) else $error("no full reset");
  a_lp: assert property (p_lp) else $error("sleep flags late");
  a_sp: assert property (p_sp) else $error("no pc clear");
  a_keep: assert property (p_keep) else $error("control lost");
  a_pin: assert property (p_pin) else $error("pin not held");
  a_flag: assert property (p_flag) else $error("flags moved");
  a_lvr: assert property (p_lvr) else $error("dip not filtered");
endmodule
`default_nettype wire

// ### rseq_partner.sv
// far side: reset pin, supply monitor, watchdog
`timescale 1ns/1ps
`default_nettype none
module rseq_partner (
  // lines to the sequencer
  input wire logic clk,
  output logic external_reset_pin_n = 1'h1,
  output logic supply_low = 1'h0,
  output logic wdt_expire = 1'h0
);
  // drive one line for n clocks, then idle
  task automatic pulse(input int sel, input int n);
    if (sel == 0) external_reset_pin_n <= 1'h0;
    if (sel == 1) supply_low <= 1'h1;
    if (sel == 2) wdt_expire <= 1'h1;
    repeat (n) @(posedge clk);
    external_reset_pin_n <= 1'h1;
    supply_low <= 1'h0;
    wdt_expire <= 1'h0;
  endtask
endmodule
`default_nettype wire

// ### reset_sequencer_flags_bench.sv
// self-checking bench for the reset sequencer
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer_flags_bench;
  localparam int D = 20;
  logic clk = 1'h0, rstn = 1'h0, low_power_mode = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, q;
  logic avs_waitrequest, core_hold, low_voltage_reset, timeout_flag, powerdown_flag, irq, ia;
  logic timer_enable, int_enable, wdt_count_clear;
  logic [7:0] watchdog_control_reg, system_mode_reg, port_a_data, port_a_direction;
  logic [2:0] stack_ptr;
  wire logic external_reset_pin_n, supply_low, wdt_expire;
  rseq_pkg::rseq_init_t init_strobe;
  int n_mismatch = 0, checked = 0, c;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  rseq_partner pm_u (.clk, .external_reset_pin_n, .supply_low, .wdt_expire);
  rseq_top #(.POWERON_DELAY_CYC(D)) dut_u (.clk, .rstn, .external_reset_pin_n, .supply_low,
    .wdt_expire, .low_power_mode, .halt_entry(1'h0), .wdt_clear_insn(1'h0), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .core_hold, .init_strobe, .low_voltage_reset, .wdt_count_clear,
    .timeout_flag, .powerdown_flag, .watchdog_control_reg, .system_mode_reg, .port_a_data,
    .port_a_direction, .stack_ptr, .timer_enable, .int_enable, .irq);
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one avalon transfer, read data into q
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    {avs_write, avs_read} <= {w, !w};
    @(posedge clk);
    while (avs_waitrequest !== 1'h0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) n_mismatch++;
    q = avs_readdata;
    {avs_write, avs_read} <= 2'h0;
    @(posedge clk);
  endtask
  // clocks spent with the core held
  task automatic held(input int lo, input int hi);
    c = 0;
    while (core_hold === 1'h1 && c < 2000) begin
      @(posedge clk);
      c++;
    end
    chk(c >= lo && c <= hi, 1'h1);
  endtask
  // verdict
  task automatic stop_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // power-on values and delay
  task automatic t_por();
    chk({init_strobe, wdt_count_clear}, 4'hf);
    chk({timeout_flag, powerdown_flag, stack_ptr}, 5'h07);
    chk({watchdog_control_reg, system_mode_reg}, 16'h7a03);
    chk({port_a_data, port_a_direction}, 16'hffff);
    chk({int_enable, timer_enable}, 2'h0);
    held(D, D + 4);
    bus(1'h0, 4'h0, 32'h0000_0000);
    chk(q[2:0], 3'h4);
    bus(1'h0, 4'h2, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk({wdt_count_clear, init_strobe}, 4'h0);
    $display("por done");
  endtask
  // expiry while running
  task automatic t_wdt();
    pm_u.pulse(2, 1);
    repeat (3) @(posedge clk);
    chk({timeout_flag, powerdown_flag, core_hold}, 3'h5);
    chk({int_enable, timer_enable}, 2'h0);
    held(D - 3, D + 4);
    $display("wdt done");
  endtask
  // expiry while asleep, per oscillator
  task automatic t_wake(input logic [1:0] osc, input int n);
    bus(1'h1, 4'hc, {30'h0, osc});
    low_power_mode <= 1'h1;
    @(posedge clk);
    pm_u.pulse(2, 1);
    low_power_mode <= 1'h0;
    repeat (2) @(posedge clk);
    chk({int_enable, timer_enable}, 2'h3);
    held(n - 3, n + 3);
    chk({timeout_flag, powerdown_flag, stack_ptr}, 5'h18);
    chk(watchdog_control_reg, 8'h7a);
    $display("wake done");
  endtask
  // pin reset, then interrupt mask and clear
  task automatic t_pin();
    pm_u.pulse(0, 10);
    chk({core_hold, timeout_flag, powerdown_flag}, 3'h7);
    held(D, D + 6);
    bus(1'h0, 4'h4, 32'h0000_0000);
    chk(q[0], 1'h1);
    bus(1'h1, 4'h8, 32'h0000_0007);
    @(posedge clk);
    ia = irq;
    bus(1'h1, 4'h8, 32'h0000_0000);
    @(posedge clk);
    chk(ia ^ irq, 1'h1);
    bus(1'h1, 4'h4, 32'h0000_0007);
    bus(1'h0, 4'h4, 32'h0000_0000);
    chk({q[2:0], irq}, 4'h0);
    $display("pin done");
  endtask
  // short dip ignored, long dip resets
  task automatic t_lvr();
    pm_u.pulse(1, 50);
    repeat (20) @(posedge clk);
    chk({low_voltage_reset, core_hold}, 2'h0);
    pm_u.pulse(1, 300);
    chk({low_voltage_reset, core_hold, timeout_flag, powerdown_flag}, 4'hf);
    held(D, D + 300);
    $display("lvr done");
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'h1;
    t_por();
    t_wdt();
    t_wake(rseq_pkg::RSEQ_OSC_RC, 16);
    t_wake(rseq_pkg::RSEQ_OSC_XTAL, 1024);
    t_wake(rseq_pkg::RSEQ_OSC_SLOW_RC, 2);
    t_pin();
    t_lvr();
    stop_test();
  end
  // hang guard
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
endmodule
bind rseq_top rseq_props props_u (.clk, .rstn, .external_reset_pin_n, .supply_low,
  .wdt_expire, .low_power_mode, .core_hold, .init_strobe, .low_voltage_reset,
  .timeout_flag, .powerdown_flag, .watchdog_control_reg);
`default_nettype wire
